// File: logic/tvs_consts.svh
// Constants for the TV sound status readback block
`ifndef TVS_CONSTS_SVH
`define TVS_CONSTS_SVH

// ****************************************
// Subaddresses
// ****************************************
`define TVS_SA_DEV_STATUS   8'h00
`define TVS_SA_DA_STATUS    8'h01
`define TVS_SA_ERR_COUNT    8'h02
`define TVS_SA_ADD_LOW      8'h03
`define TVS_SA_ADD_HIGH     8'h04
`define TVS_SA_LEVEL_HIGH   8'h05
`define TVS_SA_LEVEL_LOW    8'h06
`define TVS_SA_INPUT_LEVEL  8'h07
`define TVS_SA_TEST_B       8'hFC
`define TVS_SA_TEST_A       8'hFD
`define TVS_SA_PART_ID      8'hFE
`define TVS_SA_FW_ID        8'hFF

// ****************************************
// Field positions and values
// ****************************************
`define TVS_DS_PORT_TWO     7
`define TVS_DS_PORT_ONE     6
`define TVS_DS_RESERVE      5
`define TVS_DS_AUTOMUTE     4
`define TVS_DS_SOUND_VALID  3
`define TVS_DS_FM_DUAL      2
`define TVS_DS_FM_STEREO    1
`define TVS_DS_SUPPLY_DIP   0
`define TVS_DA_CTRL_HI      7
`define TVS_DA_CTRL_LO      5
`define TVS_DA_FRAME_SYNC   3
`define TVS_DA_CFG_CHANGE   2
`define TVS_DA_STEREO       1
`define TVS_DA_DUAL_MONO    0
`define TVS_ADD_HIGH_MASK   8'hDF
`define TVS_INPUT_LVL_MASK  8'h9F
`define TVS_READ_NONE       8'hFF
`define TVS_SA_STEP         8'h01
`define TVS_BYTE_BITS       4'h8
`define TVS_BIT_ONE         4'h1
`define TVS_CNT_ZERO        4'h0

`endif

// File: logic/tvs_pkg.sv
// Types for the TV sound status readback block
`default_nettype none
package tvs_pkg;

	typedef enum logic [8:0] {
		TVS_IDLE     = 9'h001,
		TVS_ADDR     = 9'h002,
		TVS_ADDR_ACK = 9'h004,
		TVS_SUB      = 9'h008,
		TVS_SUB_ACK  = 9'h010,
		TVS_WR       = 9'h020,
		TVS_WR_ACK   = 9'h040,
		TVS_TX       = 9'h080,
		TVS_TX_ACK   = 9'h100
	} tvs_state_t;

endpackage
`default_nettype wire

// File: logic/tvs_status_readback.sv
// Status register bank read by a two-wire host in slave transmitter mode
//
// Function
// - Status bits 7 and 6 show live levels of port pins two and one.
// - Status bit 5 mirrors the reserve-sound control bit of digital status.
// - Status bit 4 is high while auto-mute plays the first carrier.
// - Status bit 3 is one when the digital transmission carries sound.
// - Status bit 2 flags FM dual; both id bits clear means FM mono.
// - Status bit 1 flags FM stereo on two-carrier FM systems.
// - Status bit 0 is a sticky flag set by a digital supply dip.
// - Write subaddress, repeated start, read; subaddress increments per byte.
// - Subaddress wraps 255 to 0; missing subaddresses read all ones.
// - Frame sync bit is one only with frame and 16-frame sync.
`timescale 1ns/10ps
`include "tvs_consts.svh"
`default_nettype none

module tvs_status_readback
	import tvs_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR     = 7'h2B,
	parameter logic [7:0] TEST_B_VALUE = 8'h00,
	parameter logic [7:0] TEST_A_VALUE = 8'h00,
	parameter logic [7:0] PART_ID      = 8'h5A,
	parameter logic [7:0] FW_ID        = 8'hA5
) (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output var  logic       sda_o,
	output var  logic       sda_oe_n,
	input  wire logic       general_port_pin_one,
	input  wire logic       general_port_pin_two,
	input  wire logic       reserve_sound_control,
	input  wire logic [2:0] app_control_bits,
	input  wire logic       frame_sync_in,
	input  wire logic       sf16_sync_in,
	input  wire logic       config_change_flag,
	input  wire logic       digital_stereo_flag,
	input  wire logic       digital_dual_mono_flag,
	input  wire logic       automute_active,
	input  wire logic       digital_sound_valid,
	input  wire logic       fm_dual_detected,
	input  wire logic       fm_stereo_detected,
	input  wire logic       supply_dip_event,
	input  wire logic       supply_dip_clear,
	input  wire logic [7:0] digital_error_count,
	input  wire logic [7:0] additional_data_low,
	input  wire logic [7:0] additional_data_high,
	input  wire logic [7:0] level_readout_high,
	input  wire logic [7:0] level_readout_low,
	input  wire logic [7:0] input_level,
	output var  logic       supply_dip_flag,
	output var  logic       additional_data_read
);

	// PART_ID, FW_ID and DEV_ADDR defaults are arbitrary values

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] scl_sync_r;
	logic [2:0] sda_sync_r;
	logic [1:0] port_one_sync_r;
	logic [1:0] port_two_sync_r;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			scl_sync_r <= 3'h7;
			sda_sync_r <= 3'h7;
		end else begin
			scl_sync_r <= {scl_sync_r[1:0], scl_i};
			sda_sync_r <= {sda_sync_r[1:0], sda_i};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			port_one_sync_r <= 2'h0;
			port_two_sync_r <= 2'h0;
		end else begin
			port_one_sync_r <= {port_one_sync_r[0], general_port_pin_one};
			port_two_sync_r <= {port_two_sync_r[0], general_port_pin_two};
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic sda_now;

	assign sda_now   = sda_sync_r[1];
	assign scl_rise  = scl_sync_r[1] & ~scl_sync_r[2];
	assign scl_fall  = ~scl_sync_r[1] & scl_sync_r[2];
	assign bus_start = scl_sync_r[1] & scl_sync_r[2] &
		~sda_sync_r[1] & sda_sync_r[2];
	assign bus_stop  = scl_sync_r[1] & scl_sync_r[2] &
		sda_sync_r[1] & ~sda_sync_r[2];

	// ****************************************
	// Supply dip flag
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			supply_dip_flag <= 1'b0;
		end else if (supply_dip_event) begin
			supply_dip_flag <= 1'b1;
		end else if (supply_dip_clear) begin
			supply_dip_flag <= 1'b0;
		end
	end

	// ****************************************
	// Status byte images
	// ****************************************
	logic [7:0] dev_status;
	logic [7:0] da_status;

	always_comb begin
		dev_status = 8'h00;
		dev_status[`TVS_DS_PORT_TWO]    = port_two_sync_r[1];
		dev_status[`TVS_DS_PORT_ONE]    = port_one_sync_r[1];
		dev_status[`TVS_DS_RESERVE]     = reserve_sound_control;
		dev_status[`TVS_DS_AUTOMUTE]    = automute_active;
		dev_status[`TVS_DS_SOUND_VALID] = digital_sound_valid;
		dev_status[`TVS_DS_FM_DUAL]     = fm_dual_detected;
		dev_status[`TVS_DS_FM_STEREO]   = fm_stereo_detected;
		dev_status[`TVS_DS_SUPPLY_DIP]  = supply_dip_flag;
	end

	always_comb begin
		da_status = 8'h00;
		da_status[`TVS_DA_CTRL_HI] = reserve_sound_control;
		da_status[`TVS_DA_CTRL_HI-1:`TVS_DA_CTRL_LO-1] = app_control_bits;
		da_status[`TVS_DA_FRAME_SYNC] = frame_sync_in & sf16_sync_in;
		da_status[`TVS_DA_CFG_CHANGE] = config_change_flag;
		da_status[`TVS_DA_STEREO]     = digital_stereo_flag;
		da_status[`TVS_DA_DUAL_MONO]  = digital_dual_mono_flag;
	end

	// ****************************************
	// Read multiplexer
	// ****************************************
	tvs_state_t state_r;
	logic [7:0] subaddr_r;
	logic [7:0] rd_addr;
	logic [7:0] rd_byte;

	// Next byte of an auto-increment run comes from the following location
	assign rd_addr = (state_r == TVS_TX_ACK) ?
		8'(subaddr_r + `TVS_SA_STEP) : subaddr_r;

	always_comb begin
		case (rd_addr)
			`TVS_SA_DEV_STATUS:  rd_byte = dev_status;
			`TVS_SA_DA_STATUS:   rd_byte = da_status;
			`TVS_SA_ERR_COUNT:   rd_byte = digital_error_count;
			`TVS_SA_ADD_LOW:     rd_byte = additional_data_low;
			`TVS_SA_ADD_HIGH:
				rd_byte = additional_data_high & `TVS_ADD_HIGH_MASK;
			`TVS_SA_LEVEL_HIGH:  rd_byte = level_readout_high;
			`TVS_SA_LEVEL_LOW:   rd_byte = level_readout_low;
			`TVS_SA_INPUT_LEVEL:
				rd_byte = input_level & `TVS_INPUT_LVL_MASK;
			`TVS_SA_TEST_B:      rd_byte = TEST_B_VALUE;
			`TVS_SA_TEST_A:      rd_byte = TEST_A_VALUE;
			`TVS_SA_PART_ID:     rd_byte = PART_ID;
			`TVS_SA_FW_ID:       rd_byte = FW_ID;
			default:             rd_byte = `TVS_READ_NONE;
		endcase
	end

	// ****************************************
	// Bus protocol engine
	// ****************************************
	logic [3:0] bit_cnt_r;
	logic [7:0] rx_shift_r;
	logic [7:0] tx_shift_r;
	logic       read_dir_r;
	logic       host_nack_r;
	logic       load_byte;

	assign load_byte = scl_fall & (
		((state_r == TVS_ADDR_ACK) & read_dir_r) |
		((state_r == TVS_TX_ACK) & ~host_nack_r));

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_r <= TVS_IDLE;
		end else if (bus_stop) begin
			state_r <= TVS_IDLE;
		end else if (bus_start) begin
			state_r <= TVS_ADDR;
		end else if (scl_fall) begin
			case (state_r)
				TVS_ADDR: begin
					if (bit_cnt_r == `TVS_BYTE_BITS) begin
						if (rx_shift_r[7:1] == DEV_ADDR) begin
							state_r <= TVS_ADDR_ACK;
						end else begin
							state_r <= TVS_IDLE;
						end
					end
				end
				TVS_ADDR_ACK: state_r <= read_dir_r ? TVS_TX : TVS_SUB;
				TVS_SUB: begin
					if (bit_cnt_r == `TVS_BYTE_BITS) begin
						state_r <= TVS_SUB_ACK;
					end
				end
				TVS_SUB_ACK: state_r <= TVS_WR;
				TVS_WR: begin
					if (bit_cnt_r == `TVS_BYTE_BITS) begin
						state_r <= TVS_WR_ACK;
					end
				end
				TVS_WR_ACK: state_r <= TVS_WR;
				TVS_TX: begin
					if (bit_cnt_r == `TVS_BYTE_BITS) begin
						state_r <= TVS_TX_ACK;
					end
				end
				TVS_TX_ACK: begin
					state_r <= host_nack_r ? TVS_IDLE : TVS_TX;
				end
				default: state_r <= TVS_IDLE;
			endcase
		end
	end

	// Bit counter and receive shifter
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			bit_cnt_r  <= `TVS_CNT_ZERO;
			rx_shift_r <= 8'h00;
		end else if (bus_start) begin
			bit_cnt_r <= `TVS_CNT_ZERO;
		end else if (load_byte) begin
			bit_cnt_r <= `TVS_BIT_ONE;
		end else if (scl_fall & ((state_r == TVS_ADDR_ACK) |
			(state_r == TVS_SUB_ACK) | (state_r == TVS_WR_ACK))) begin
			bit_cnt_r <= `TVS_CNT_ZERO;
		end else if (scl_fall & (state_r == TVS_TX) &
			(bit_cnt_r != `TVS_BYTE_BITS)) begin
			bit_cnt_r <= 4'(bit_cnt_r + `TVS_BIT_ONE);
		end else if (scl_rise & ((state_r == TVS_ADDR) |
			(state_r == TVS_SUB) | (state_r == TVS_WR))) begin
			rx_shift_r <= {rx_shift_r[6:0], sda_now};
			bit_cnt_r  <= 4'(bit_cnt_r + `TVS_BIT_ONE);
		end
	end

	// Direction bit and host acknowledge
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			read_dir_r  <= 1'b0;
			host_nack_r <= 1'b1;
		end else begin
			if (scl_fall & (state_r == TVS_ADDR) &
				(bit_cnt_r == `TVS_BYTE_BITS)) begin
				read_dir_r <= rx_shift_r[0];
			end
			if (scl_rise & (state_r == TVS_TX_ACK)) begin
				host_nack_r <= sda_now;
			end
		end
	end

	// Subaddress pointer, written by the subaddress byte and stepped on each further read byte
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			subaddr_r <= 8'h00;
		end else if (scl_fall & (state_r == TVS_SUB) &
			(bit_cnt_r == `TVS_BYTE_BITS)) begin
			subaddr_r <= rx_shift_r;
		end else if (load_byte & (state_r == TVS_TX_ACK)) begin
			subaddr_r <= rd_addr;
		end
	end

	// Transmit shifter, loaded with bits 6 to 0 in one cycle; bit 7 goes to the pin drive
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tx_shift_r <= 8'hFF;
		end else if (load_byte) begin
			tx_shift_r <= {rd_byte[6:0], 1'b1};
		end else if (scl_fall & (state_r == TVS_TX)) begin
			tx_shift_r <= {tx_shift_r[6:0], 1'b1};
		end
	end

	// ****************************************
	// Data pin drive
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sda_o    <= 1'b0;
			sda_oe_n <= 1'b1;
		end else if (bus_start | bus_stop) begin
			sda_oe_n <= 1'b1;
		end else if (load_byte) begin
			sda_oe_n <= rd_byte[7];
		end else if (scl_fall) begin
			case (state_r)
				TVS_ADDR: sda_oe_n <= ~((bit_cnt_r == `TVS_BYTE_BITS) &
					(rx_shift_r[7:1] == DEV_ADDR));
				TVS_SUB:  sda_oe_n <= (bit_cnt_r != `TVS_BYTE_BITS);
				TVS_WR:   sda_oe_n <= (bit_cnt_r != `TVS_BYTE_BITS);
				TVS_TX:   sda_oe_n <= (bit_cnt_r == `TVS_BYTE_BITS) |
					tx_shift_r[7];
				default:  sda_oe_n <= 1'b1;
			endcase
		end
	end

	// ****************************************
	// Read side effects
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			additional_data_read <= 1'b0;
		end else begin
			additional_data_read <= load_byte &
				(rd_addr == `TVS_SA_ADD_HIGH);
		end
	end

endmodule
`default_nettype wire

// File: bench/tvs_status_readback_checker.sv
// Port assertions for the status readback bank
`timescale 1ns/10ps
`default_nettype none

module tvs_status_readback_checker (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_n,
	input wire logic supply_dip_event,
	input wire logic supply_dip_clear,
	input wire logic supply_dip_flag,
	input wire logic additional_data_read
);
	// ********
	// Properties
	// ********
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_reset_idle: assert property (disable iff (1'b0)
		!resetn |=> sda_oe_n && !supply_dip_flag && !additional_data_read)
		else $error("outputs not idle after reset");
	a_dip_sets: assert property (supply_dip_event |-> ##[1:2] supply_dip_flag)
		else $error("supply dip not flagged");
	a_dip_sticky: assert property (
		supply_dip_flag && !supply_dip_clear |=> supply_dip_flag)
		else $error("supply flag lost without clear");
	a_dip_cleared: assert property (
		$fell(supply_dip_flag) |-> $past(supply_dip_clear))
		else $error("supply flag fell without clear");
	a_dip_cause: assert property ($rose(supply_dip_flag) |->
		$past(supply_dip_event) || $past(supply_dip_event, 2))
		else $error("supply flag rose without event");
	a_drive_zero: assert property (!sda_oe_n |-> !sda_o)
		else $error("data pin driven high");
	a_drive_scl_low: assert property ($changed(sda_oe_n) |->
		!scl_i && !$past(scl_i, 2))
		else $error("data pin changed near bus clock high");
	a_sad_pulse: assert property (
		additional_data_read |=> !additional_data_read)
		else $error("read pulse longer than one cycle");
	a_sad_scl_low: assert property (additional_data_read |-> !scl_i)
		else $error("byte capture outside bus clock low");

	c_dip: cover property ($rose(supply_dip_flag));
	c_sad: cover property (additional_data_read);
	c_drive: cover property ($fell(sda_oe_n));
endmodule

bind tvs_status_readback tvs_status_readback_checker chk_i (
	.core_clk            (core_clk),
	.resetn              (resetn),
	.scl_i               (scl_i),
	.sda_o               (sda_o),
	.sda_oe_n            (sda_oe_n),
	.supply_dip_event    (supply_dip_event),
	.supply_dip_clear    (supply_dip_clear),
	.supply_dip_flag     (supply_dip_flag),
	.additional_data_read(additional_data_read)
);
`default_nettype wire

// File: bench/tvs_host_model.sv
// Two-wire bus host model that reads the status bank
`timescale 1ns/10ps
`default_nettype none

module tvs_host_model (
	input  wire logic core_clk,
	input  wire logic sda_line,
	output var  logic scl,
	output var  logic sda_drv
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// ********
	// Bus phases
	// ********
	task automatic gap();
		repeat (10) @(negedge core_clk);
	endtask
	// Start or repeated start, line released first
	task automatic start();
		sda_drv = 1'b1;
		gap();
		scl = 1'b1;
		gap();
		sda_drv = 1'b0;
		gap();
		scl = 1'b0;
	endtask
	task automatic stop();
		sda_drv = 1'b0;
		gap();
		scl = 1'b1;
		gap();
		sda_drv = 1'b1;
		gap();
	endtask
	// Eight data bits then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic ack);
		logic [8:0] w;
		logic [8:0] r;
		w = {d, last};
		for (int i = 8; i >= 0; i--) begin
			gap();
			sda_drv = w[i];
			gap();
			scl = 1'b1;
			gap();
			r[i] = sda_line;
			scl = 1'b0;
		end
		q = r[8:1];
		ack = ~r[0];
	endtask
endmodule
`default_nettype wire

// File: bench/tb_tvs_status_readback.sv
// Self-checking bench for the status readback bank
`timescale 1ns/10ps
`include "tvs_consts.svh"
`default_nettype none

module tb_tvs_status_readback;
	localparam logic [6:0] ADDR = 7'h2B;
	localparam logic [7:0] PART = 8'h3C; // Arbitrary value
	localparam logic [7:0] FW   = 8'hC3; // Arbitrary value
	logic       core_clk, resetn, scl, sda_drv, sda_o, sda_oe_n;
	logic       flag, adr, fs, sf, cfg, dst, ddm, dev, dclr, dip_exp;
	logic [7:1] st;
	logic [2:0] app;
	logic [7:0] err, adl, adh, lvh, lvl, inl, q;
	logic       a;
	logic [7:0] got [0:9];
	int         n_mismatch, total_checks;
	wire        sda = sda_drv & (sda_oe_n | sda_o);
	logic [7:0] sad_cnt = 8'h00;

	tvs_host_model host (.core_clk(core_clk), .sda_line(sda),
		.scl(scl), .sda_drv(sda_drv));
	tvs_status_readback #(.DEV_ADDR(ADDR), .TEST_B_VALUE(8'h11),
		.TEST_A_VALUE(8'h22), .PART_ID(PART), .FW_ID(FW)) uut (
		.core_clk(core_clk), .resetn(resetn), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n),
		.general_port_pin_one(st[6]), .general_port_pin_two(st[7]),
		.reserve_sound_control(st[5]), .app_control_bits(app),
		.frame_sync_in(fs), .sf16_sync_in(sf), .config_change_flag(cfg),
		.digital_stereo_flag(dst), .digital_dual_mono_flag(ddm),
		.automute_active(st[4]), .digital_sound_valid(st[3]),
		.fm_dual_detected(st[2]), .fm_stereo_detected(st[1]),
		.supply_dip_event(dev), .supply_dip_clear(dclr),
		.digital_error_count(err), .additional_data_low(adl),
		.additional_data_high(adh), .level_readout_high(lvh),
		.level_readout_low(lvl), .input_level(inl),
		.supply_dip_flag(flag), .additional_data_read(adr));

	always #2.5 core_clk = ~core_clk;
	// Counts read pulses of the additional data high byte
	always @(posedge core_clk) if (adr) sad_cnt <= sad_cnt + 8'h01;
	// ********
	// Tasks
	// ********
	function automatic logic [7:0] exp_byte(input logic [7:0] sa);
		case (sa)
			8'h00: return {st, dip_exp};
			8'h01: return {st[5], app, fs & sf, cfg, dst, ddm};
			8'h02: return err;
			8'h03: return adl;
			8'h04: return adh & `TVS_ADD_HIGH_MASK;
			8'h05: return lvh;
			8'h06: return lvl;
			8'h07: return inl & `TVS_INPUT_LVL_MASK;
			8'hFC: return 8'h11;
			8'hFD: return 8'h22;
			8'hFE: return PART;
			8'hFF: return FW;
			default: return `TVS_READ_NONE;
		endcase
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rd(input logic [7:0] sa, input int n);
		host.start();
		host.xfer({ADDR, 1'b0}, 1'b1, q, a);
		chk({7'h00, a}, 8'h01);
		host.xfer(sa, 1'b1, q, a);
		chk({7'h00, a}, 8'h01);
		host.start();
		host.xfer({ADDR, 1'b1}, 1'b1, q, a);
		chk({7'h00, a}, 8'h01);
		for (int i = 0; i < n; i++)
			host.xfer(8'hFF, i == n - 1, got[i], a);
		host.stop();
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ********
	// Scenarios
	// ********
	initial begin
		repeat (60000) @(posedge core_clk);
		$display("ERROR %0t run did not finish in time", $time);
		n_mismatch++;
		give_verdict();
	end
	initial begin
		{core_clk, resetn, st, app, fs, sf} = {1'b0, 1'b0, 7'h00, 3'h5, 2'h2};
		{cfg, dst, ddm, dev, dclr, dip_exp} = 6'h28;
		{err, adl, adh, lvh, lvl, inl} = 48'h3CC5FF817EFF;
		repeat (4) @(negedge core_clk);
		resetn = 1'b1;
		repeat (4) @(negedge core_clk);
		for (int k = 0; k < 4; k++) begin
			st = (k == 0) ? 7'h55 : (k == 1) ? 7'h2A : (k == 2) ? 7'h7F : 7'h00;
			rd(8'h00, 1);
			chk(got[0], exp_byte(8'h00));
		end
		dev = 1'b1;
		@(negedge core_clk) dev = 1'b0;
		dip_exp = 1'b1;
		repeat (3) @(negedge core_clk);
		chk({7'h00, flag}, 8'h01);
		rd(8'h00, 1);
		chk(got[0], exp_byte(8'h00));
		{dev, dclr} = 2'h3;
		@(negedge core_clk) {dev, dclr} = 2'h1;
		chk({7'h00, flag}, 8'h01);
		@(negedge core_clk) dclr = 1'b0;
		dip_exp = 1'b0;
		repeat (3) @(negedge core_clk);
		chk({7'h00, flag}, 8'h00);
		rd(8'h00, 9);
		for (int i = 0; i < 9; i++)
			chk(got[i], exp_byte(8'(i)));
		chk(sad_cnt, 8'h01);
		sf = 1'b1;
		rd(8'hFC, 6);
		for (int i = 0; i < 6; i++)
			chk(got[i], exp_byte(8'hFC + 8'(i)));
		host.start();
		host.xfer({ADDR, 1'b0}, 1'b1, q, a);
		host.xfer(8'h00, 1'b1, q, a);
		host.xfer(8'hFF, 1'b1, q, a);
		chk({7'h00, a}, 8'h01);
		host.stop();
		rd(8'h00, 2);
		chk(got[0], exp_byte(8'h00));
		chk(got[1], exp_byte(8'h01));
		host.start();
		host.xfer({ADDR, 1'b1}, 1'b1, q, a);
		chk({7'h00, a}, 8'h01);
		host.xfer(8'hFF, 1'b1, got[0], a);
		host.stop();
		chk(got[0], exp_byte(8'h01));
		dev = 1'b1;
		@(negedge core_clk) {dev, resetn} = 2'h0;
		chk({7'h00, flag}, 8'h01);
		repeat (4) @(negedge core_clk);
		resetn = 1'b1;
		repeat (4) @(negedge core_clk);
		chk({7'h00, flag}, 8'h00);
		host.start();
		host.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
		host.stop();
		chk({7'h00, a}, 8'h00);
		give_verdict();
	end
endmodule
`default_nettype wire
